// ### rtl/sbc_ctrl_regs.sv
// software command and boost control register bank with watchdog
`timescale 1ns/1ps
// Contract
// RULE_01 - 100 in top bits selects software register
// RULE_02 - toggle bit D12 copied to status D11
// RULE_03 - host checks link by toggle readback
// RULE_04 - key 0x555 performs full software reset
// RULE_05 - host sends 0x195 before each timeout
// RULE_06 - missed watchdog service raises fault alert
// RULE_07 - 011 selects boost control, D12..D7 ignored
// RULE_08 - D6 picks internal or external compensation
// RULE_09 - D5..D4 set channel clock phasing
// RULE_10 - D3..D2 divide oscillator for switching rate
// RULE_11 - D1..D0 cap boost rail voltage
// RULE_12 - slew control held per output channel
// RULE_13 - status register is read only
// RULE_14 - software reset restores boost defaults
module sbc_ctrl_regs
    import sbc_pkg::*;
#(
    parameter int unsigned WDT_CYC = SBC_WDT_CYC
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        wr_valid,
    input  wire logic [15:0] wr_data,
    input  wire logic [1:0]  slew_chan,
    input  wire logic        wdt_enable,
    input  wire logic        osc_tick,
    output logic             user_toggle,
    output logic             soft_reset,
    output logic             fault_alert,
    output logic             compensation_select,
    output logic [1:0]       converter_phase_select,
    output logic [1:0]       switching_rate_select,
    output logic [1:0]       boost_limit_select,
    output logic [31:0]      slew_ctrl,
    output logic [3:0]       chan_clk
);
    logic       is_soft, is_boost, is_slew, key_rst, key_srv;
    logic       tog_q, tog_d, srst_q, srst_d, alert_q, alert_d;
    logic       comp_q, comp_d;
    logic [1:0] phase_q, phase_d, rate_q, rate_d, lim_q, lim_d;
    logic [SBC_WDT_W-1:0] wdt_q, wdt_d;
    logic [SBC_SLEW_W-1:0] slew_q [SBC_CH];
    logic [SBC_SLEW_W-1:0] slew_d [SBC_CH];

    // ----------------------------------------------------------------
    // word decode
    // ----------------------------------------------------------------
    always_comb begin
        is_soft  = wr_valid &&
            wr_data[SBC_SEL_MSB:SBC_SEL_LSB] == SBC_SEL_SOFT;  // see RULE_01
        is_boost = wr_valid &&
            wr_data[SBC_SEL_MSB:SBC_SEL_LSB] == SBC_SEL_BOOST; // see RULE_07
        is_slew  = wr_valid &&
            wr_data[SBC_SEL_MSB:SBC_SEL_LSB] == SBC_SEL_SLEW;
        key_rst  = is_soft && wr_data[11:0] == SBC_KEY_RESET;
        key_srv  = is_soft && wr_data[11:0] == SBC_KEY_SERVE;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // reset key wins over anything else in the same word
    always_comb begin
        tog_d   = tog_q;
        comp_d  = comp_q;
        phase_d = phase_q;
        rate_d  = rate_q;
        lim_d   = lim_q;
        slew_d  = slew_q;
        srst_d  = key_rst;                          // see RULE_04
        alert_d = alert_q;
        wdt_d   = wdt_q;
        if (is_soft) begin
            tog_d = wr_data[SBC_TOGGLE];            // see RULE_02
        end
        if (is_boost) begin
            // bits 12..7 are not looked at
            comp_d  = wr_data[SBC_COMP_BIT];        // see RULE_08
            phase_d = wr_data[5:4];                 // see RULE_09
            rate_d  = wr_data[3:2];                 // see RULE_10
            lim_d   = wr_data[1:0];                 // see RULE_11
        end
        if (is_slew) begin
            slew_d[slew_chan] = wr_data[7:0];       // see RULE_12
        end
        // watchdog: a service key reloads, expiry latches the alert
        if (!wdt_enable || key_srv) begin
            wdt_d = '0;
        end else if (wdt_q >= SBC_WDT_W'(WDT_CYC - 1)) begin
            alert_d = 1'b1;                         // see RULE_06
        end else begin
            wdt_d = wdt_q + 1'b1;
        end
        if (key_rst) begin
            tog_d   = 1'b0;
            comp_d  = SBC_COMP_RST;                 // see RULE_14
            phase_d = SBC_PHASE_RST;
            rate_d  = SBC_FREQ_RST;
            lim_d   = SBC_LIMIT_RST;
            alert_d = 1'b0;
            wdt_d   = '0;
            for (int i = 0; i < SBC_CH; i++) begin
                slew_d[i] = SBC_SLEW_RST;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tog_q   <= 1'b0;
            srst_q  <= 1'b0;
            alert_q <= 1'b0;
            comp_q  <= SBC_COMP_RST;
            phase_q <= SBC_PHASE_RST;
            rate_q  <= SBC_FREQ_RST;
            lim_q   <= SBC_LIMIT_RST;
            wdt_q   <= '0;
            for (int i = 0; i < SBC_CH; i++) begin
                slew_q[i] <= SBC_SLEW_RST;
            end
        end else if (ce) begin
            tog_q   <= tog_d;
            srst_q  <= srst_d;
            alert_q <= alert_d;
            comp_q  <= comp_d;
            phase_q <= phase_d;
            rate_q  <= rate_d;
            lim_q   <= lim_d;
            wdt_q   <= wdt_d;
            slew_q  <= slew_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // status toggle is only ever driven from here, never written
    assign user_toggle            = tog_q;          // see RULE_13
    assign soft_reset             = srst_q;
    assign fault_alert            = alert_q;
    assign compensation_select    = comp_q;
    assign converter_phase_select = phase_q;
    assign switching_rate_select  = rate_q;
    assign boost_limit_select     = lim_q;
    assign slew_ctrl = {slew_q[3], slew_q[2], slew_q[1], slew_q[0]};

    sbc_phase_gen u_phase (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .ce        (ce),
        .osc_tick  (osc_tick),
        .rate_sel  (rate_q),
        .phase_sel (phase_q),
        .chan_clk  (chan_clk)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_toggle_copy: assert property (@(posedge mclk) disable iff (!arst_n)
        ce && is_soft && !key_rst |=> tog_q == $past(wr_data[12]))  // see RULE_02
        else $error("toggle not copied");
    a_reset_key: assert property (@(posedge mclk) disable iff (!arst_n)
        ce && key_rst |=> soft_reset && rate_q == SBC_FREQ_RST)     // see RULE_04
        else $error("reset key missed");
    a_boost_load: assert property (@(posedge mclk) disable iff (!arst_n)
        ce && is_boost |=> {comp_q, phase_q, rate_q, lim_q}
            == $past(wr_data[6:0]))                                 // see RULE_07
        else $error("boost word not loaded");
    a_alert_expire: assert property (@(posedge mclk) disable iff (!arst_n)
        ce && wdt_enable && !key_srv && !key_rst
        && wdt_q >= SBC_WDT_W'(WDT_CYC - 1) |=> fault_alert)        // see RULE_06
        else $error("watchdog expiry not flagged");
    a_alert_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        fault_alert && !(ce && key_rst) |=> fault_alert)            // see RULE_06
        else $error("alert dropped");
    a_srv_reload: assert property (@(posedge mclk) disable iff (!arst_n)
        ce && key_srv |=> wdt_q == '0)                              // see RULE_05
        else $error("service key did not reload");
    a_rst_defaults: assert property (@(posedge mclk) disable iff (!arst_n)
        ce && key_rst |=> !compensation_select && phase_q == 2'h0
            && lim_q == 2'h0)                                       // see RULE_14
        else $error("defaults not restored");
    a_boost_ignore: assert property (@(posedge mclk) disable iff (!arst_n)
        ce && !is_boost && !key_rst |=> $stable(lim_q))             // see RULE_11
        else $error("limit changed without write");
endmodule

// ### rtl/sbc_phase_gen.sv
// phase generator: divides the oscillator tick into four channel clocks
`timescale 1ns/1ps
module sbc_phase_gen
    import sbc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       osc_tick,
    input  wire logic [1:0] rate_sel,
    input  wire logic [1:0] phase_sel,
    output logic      [3:0] chan_clk
);
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] period;
    logic [7:0] half;
    logic [7:0] quart;
    logic [3:0] clk_d;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    // code 11 is undefined; it falls back to the default rate
    always_comb begin
        unique case (rate_sel)
            2'h0:    period = SBC_DIV_250;
            2'h2:    period = SBC_DIV_650;
            default: period = SBC_DIV_410;
        endcase
        half  = period >> 1;
        quart = period >> 2;
        cnt_d = cnt_q;
        if (osc_tick) begin
            cnt_d = (cnt_q >= period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
        end
    end

    // per-channel square wave with programmable offset
    function automatic logic sq(input logic [7:0] c, input logic [7:0] off,
                                input logic [7:0] p, input logic [7:0] h);
        logic [8:0] s;
        s = {1'b0, c} + {1'b0, off};
        if (s >= {1'b0, p}) begin
            s = s - {1'b0, p};
        end
        return s[7:0] < h;
    endfunction

    always_comb begin
        clk_d[0] = sq(cnt_q, 8'h00, period, half);
        unique case (phase_sel)
            2'h0: begin
                clk_d[3:1] = {3{clk_d[0]}};
            end
            2'h1: begin
                clk_d[1] = clk_d[0];
                clk_d[2] = sq(cnt_q, half, period, half);
                clk_d[3] = clk_d[2];
            end
            2'h2: begin
                clk_d[2] = clk_d[0];
                clk_d[1] = sq(cnt_q, half, period, half);
                clk_d[3] = clk_d[1];
            end
            2'h3: begin
                clk_d[1] = sq(cnt_q, quart, period, half);
                clk_d[2] = sq(cnt_q, half, period, half);
                clk_d[3] = sq(cnt_q, 8'(half + quart), period, half);
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q    <= 8'h00;
            chan_clk <= 4'h0;
        end else if (ce) begin
            cnt_q    <= cnt_d;
            chan_clk <= clk_d;
        end
    end
endmodule

// ### rtl/sbc_pkg.sv
// package: field layout, keys, reset codes and timing for the control bank
package sbc_pkg;
    // data word field positions
    localparam int unsigned SBC_SEL_MSB   = 15;
    localparam int unsigned SBC_SEL_LSB   = 13;
    localparam int unsigned SBC_TOGGLE    = 12;
    localparam int unsigned SBC_COMP_BIT  = 6;
    localparam int unsigned SBC_STAT_TOG  = 11;
    // register select codes in D15..D13
    localparam logic [2:0]  SBC_SEL_SOFT  = 3'h4;
    localparam logic [2:0]  SBC_SEL_BOOST = 3'h3;
    localparam logic [2:0]  SBC_SEL_SLEW  = 3'h0;
    // key field values
    localparam logic [11:0] SBC_KEY_RESET = 12'h555;
    localparam logic [11:0] SBC_KEY_SERVE = 12'h195;
    // boost field reset codes
    localparam logic        SBC_COMP_RST  = 1'h0;
    localparam logic [1:0]  SBC_PHASE_RST = 2'h0;
    localparam logic [1:0]  SBC_FREQ_RST  = 2'h1;
    localparam logic [1:0]  SBC_LIMIT_RST = 2'h0;
    // oscillator and switching rates, in kHz
    localparam int unsigned SBC_OSC_KHZ   = 13000;
    localparam int unsigned SBC_F250_KHZ  = 250;
    localparam int unsigned SBC_F410_KHZ  = 410;
    localparam int unsigned SBC_F650_KHZ  = 650;
    localparam int unsigned SBC_DIV_W     = 8;
    localparam logic [7:0]  SBC_DIV_250   = 8'(SBC_OSC_KHZ / SBC_F250_KHZ);
    localparam logic [7:0]  SBC_DIV_410   = 8'(SBC_OSC_KHZ / SBC_F410_KHZ);
    localparam logic [7:0]  SBC_DIV_650   = 8'(SBC_OSC_KHZ / SBC_F650_KHZ);
    // watchdog default timeout, in ms, at the 200 MHz system clock
    localparam int unsigned SBC_CLK_MHZ   = 200;
    localparam int unsigned SBC_WDT_MS    = 100;
    localparam int unsigned SBC_WDT_CYC   = SBC_WDT_MS * 1000 * SBC_CLK_MHZ;
    localparam int unsigned SBC_WDT_W     = 32;
    localparam int unsigned SBC_CH        = 4;
    localparam int unsigned SBC_SLEW_W    = 8;
    localparam logic [7:0]  SBC_SLEW_RST  = 8'h00;
endpackage

// ### sim/sbc_host_model.sv
// host model: hands decoded data words to the control bank
`timescale 1ns/1ps
module sbc_host_model (
    input  wire logic        mclk,
    output logic             wr_valid,
    output logic [15:0]      wr_data,
    output logic [1:0]       slew_chan
);
    initial begin
        wr_valid  = 1'b0;
        wr_data   = 16'h0000;
        slew_chan = 2'h0;
    end

    // one word per call; idle bus shows the inverse so stale data is no match
    task automatic send(input logic [15:0] word, input logic [1:0] ch);
        @(negedge mclk);
        wr_valid  <= 1'b1;
        wr_data   <= word;
        slew_chan <= ch;
        @(negedge mclk);
        wr_valid  <= 1'b0;
        wr_data   <= ~word;
        slew_chan <= ~ch;
    endtask

    // service key, sent well before each timeout runs out
    task automatic serve();
        send(16'h8195, 2'h0);
    endtask
endmodule

// ### sim/software_and_boost_control_regs_tb.sv
// testbench for the software command and boost control bank
`timescale 1ns/1ps
module software_and_boost_control_regs_tb;
    import sbc_pkg::*;
    localparam int unsigned WDT     = 50;
    localparam int unsigned OSC_DIV = 15;
    localparam int unsigned LIMIT   = 20000;
    logic        mclk;
    logic        arst_n;
    logic        ce;
    logic        wdt_enable;
    logic        osc_tick;
    logic        wr_valid;
    logic [15:0] wr_data;
    logic [1:0]  slew_chan;
    logic        user_toggle;
    logic        soft_reset;
    logic        fault_alert;
    logic        comp;
    logic [1:0]  phase;
    logic [1:0]  rate;
    logic [1:0]  limit;
    logic [31:0] slew_ctrl;
    logic [3:0]  chan_clk;
    int          err_count;
    int          checks;
    int          cyc;
    int          osc_cnt;

    sbc_ctrl_regs #(.WDT_CYC(WDT)) dut (.mclk(mclk), .arst_n(arst_n),
        .ce(ce), .wr_valid(wr_valid), .wr_data(wr_data),
        .slew_chan(slew_chan), .wdt_enable(wdt_enable), .osc_tick(osc_tick),
        .user_toggle(user_toggle), .soft_reset(soft_reset),
        .fault_alert(fault_alert), .compensation_select(comp),
        .converter_phase_select(phase), .switching_rate_select(rate),
        .boost_limit_select(limit), .slew_ctrl(slew_ctrl),
        .chan_clk(chan_clk));
    sbc_host_model host (.mclk(mclk), .wr_valid(wr_valid),
        .wr_data(wr_data), .slew_chan(slew_chan));

    // ------------------------------------------------------------
    // clock, oscillator tick and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // about 13 MHz: one tick every 15 system cycles
    always @(negedge mclk) begin
        osc_cnt  <= (osc_cnt == OSC_DIV - 1) ? 0 : osc_cnt + 1;
        osc_tick <= (osc_cnt == OSC_DIV - 1);
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        check("comp", 32'(comp), 32'(SBC_COMP_RST));
        check("phase", 32'(phase), 32'(SBC_PHASE_RST));
        check("rate", 32'(rate), 32'(SBC_FREQ_RST));
        check("limit", 32'(limit), 32'(SBC_LIMIT_RST));
        check("alert", 32'(fault_alert), 32'h0);
    endtask
    // toggle written then read back, key 0xabc must not reset
    task automatic t_toggle();
        host.send(16'h9abc, 2'h0);
        check("toggle_set", 32'(user_toggle), 32'h1);
        check("no_reset", 32'(soft_reset), 32'h0);
        host.send(16'h8000, 2'h0);
        check("toggle_clr", 32'(user_toggle), 32'h0);
    endtask
    // every code of each field except rate code 11, ignored bits all ones, then foreign selects
    task automatic t_boost();
        logic [15:0] w;
        for (int i = 0; i < 4; i++) begin
            w = {3'h3, 6'h3f, i[0], 2'(i), 2'((i == 3) ? 1 : i), 2'(3 - i)};
            host.send(w, 2'h0);
            check("comp", 32'(comp), 32'(i[0]));
            check("phase", 32'(phase), 32'(w[5:4]));
            check("rate", 32'(rate), 32'(w[3:2]));
            check("limit", 32'(limit), 32'(w[1:0]));
        end
        host.send(16'he0ff, 2'h0);
        host.send(16'h2aaa, 2'h0);
        check("refused", 32'({comp, phase, rate, limit}), 32'h74);
    endtask
    // slew field per channel, then key reset pulse and defaults
    task automatic t_slew_reset();
        for (int c = 0; c < 4; c++)
            host.send(16'(8'h31 + 8'(c) * 8'h11), 2'(c));
        check("slew", slew_ctrl, 32'h64534231);
        host.send(16'h9555, 2'h0);
        check("reset_pulse", 32'(soft_reset), 32'h1);
        @(negedge mclk);
        check("reset_end", 32'(soft_reset), 32'h0);
        t_defaults();
        check("slew_clr", slew_ctrl, 32'(SBC_SLEW_RST));
        // clock enable low freezes the bank, the word is lost
        ce = 1'b0;
        host.send(16'h6040, 2'h0);
        ce = 1'b1;
        check("frozen", 32'(comp), 32'h0);
    endtask
    // channel phasing at the fast rate, after one settling period
    task automatic t_phase();
        int bad;
        int diff;
        int tog;
        logic [3:0] c;
        for (int p = 0; p < 4; p++) begin
            host.send({3'h3, 7'h00, 2'(p), 2'h2, 2'h0}, 2'h0);
            repeat (400) @(negedge mclk);
            bad = 0;
            diff = 0;
            tog = 0;
            repeat (700) begin
                c = chan_clk;
                @(negedge mclk);
                if (chan_clk[0] !== c[0]) tog++;
                c = chan_clk;
                if (c !== {4{c[0]}}) diff++;
                if ((p == 0 && c !== {4{c[0]}}) ||
                    (p == 1 && (c[0] !== c[1] || c[2] !== c[3])) ||
                    (p == 2 && (c[0] !== c[2] || c[1] !== c[3]))) bad++;
            end
            check("phase_pair", 32'(bad), 32'h0);
            check("phase_split", 32'(diff > 0), 32'(p != 0));
            check("clk_runs", 32'(tog > 1), 32'h1);
        end
    endtask
    // period of channel A within ten percent of the divided oscillator
    task automatic t_rate();
        int n;
        int e;
        logic p;
        for (int r = 0; r < 3; r++) begin
            host.send({3'h3, 7'h00, 2'h0, 2'(r), 2'h0}, 2'h0);
            e = OSC_DIV * ((r == 0) ? SBC_DIV_250 :
                           (r == 1) ? SBC_DIV_410 : SBC_DIV_650);
            repeat (3) begin
                n = 0;
                do begin
                    p = chan_clk[0];
                    @(negedge mclk);
                    n++;
                end while (!(p === 1'b0 && chan_clk[0] === 1'b1) && n < 2000);
            end
            check("period", 32'(n * 10 >= e * 9 && n * 10 <= e * 11), 32'h1);
        end
    endtask
    // serviced watchdog stays quiet, a missed service raises the alert
    task automatic t_wdt();
        wdt_enable = 1'b1;
        repeat (4) begin
            repeat (30) @(negedge mclk);
            host.serve();
        end
        check("alert_quiet", 32'(fault_alert), 32'h0);
        repeat (WDT + 10) @(negedge mclk);
        check("alert_set", 32'(fault_alert), 32'h1);
        wdt_enable = 1'b0;
        host.send(16'h9555, 2'h0);
        @(negedge mclk);
        check("alert_clr", 32'(fault_alert), 32'h0);
    endtask

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        wdt_enable = 1'b0;
        osc_tick = 1'b0;
        osc_cnt = 0;
        err_count = 0;
        checks = 0;
        cyc = 0;
        repeat (16) @(negedge mclk);
        arst_n = 1'b1;
        t_defaults();
        t_toggle();
        t_boost();
        t_slew_reset();
        t_phase();
        t_rate();
        t_wdt();
        final_report();
    end
endmodule
